/* File: mst_defs.svh */
// Constants for the modem status tracker: register offsets, field positions, reset values.
// Assumes inclusion by bare name from the package and design files.
`ifndef MST_DEFS_SVH
`define MST_DEFS_SVH

// ==========================================================================
// Register byte offsets on the Avalon-MM slave
// ==========================================================================
`define MST_OFS_MODEM_LINE_STATUS 4'h0
`define MST_OFS_MODEM_CONTROL_REG 4'h4
`define MST_OFS_IRQ_STATUS        4'h8
`define MST_OFS_IRQ_MASK          4'hC

// ==========================================================================
// Field positions
// ==========================================================================
`define MST_MCR_DTR        0
`define MST_MCR_RTS        1
`define MST_MCR_OUT1       2
`define MST_MCR_OUT2       3
`define MST_MCR_LOOP       4
`define MST_MCR_FLOW       5
`define MST_MCR_W          6
`define MST_IRQ_MODEM      0
`define MST_IRQ_TXHALT     1
`define MST_IRQ_W          2

// ==========================================================================
// Reset values
// ==========================================================================
`define MST_MCR_RST        6'h00
`define MST_IRQ_RST        2'h0
`define MST_FLAGS_RST      4'h0
`define MST_PIN_IDLE       4'hF
`define MST_RDATA_RST      32'h0000_0000
// Edges after reset before edge detection starts: two synchroniser stages plus the level register.
`define MST_PRIME_EDGES    2'd3

`endif

/* File: mst_pkg.sv */
// Types shared by the modem status tracker modules.
// Assumes mst_defs.svh is on the include path.
`include "mst_defs.svh"

package mst_pkg;

    // ======================================================================
    // Modem signal group, one bit per line
    // ======================================================================
    typedef struct packed {
        logic cd;
        logic ri;
        logic dsr;
        logic cts;
    } mst_modem_t;

    // ======================================================================
    // Bus slave states
    // ======================================================================
    typedef enum logic {
        MST_BUS_IDLE,
        MST_BUS_ANSWER
    } mst_bus_state_t;

endpackage

/* File: mst_sync.sv */
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to core_clk; RST_VAL is their idle level.
`timescale 1ns/100ps
`include "mst_defs.svh"

module mst_sync #(
    parameter int               WIDTH   = 4,
    parameter logic [WIDTH-1:0] RST_VAL = `MST_PIN_IDLE
) (
    input  wire logic             core_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] pin_async,
    output logic      [WIDTH-1:0] pin_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // ======================================================================
    // First stage is read only by the second stage.
    // ======================================================================
    always_comb begin
        meta_d = pin_async;
        sync_d = meta_q;
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    meta_q[i] <= RST_VAL[i];
                    sync_q[i] <= RST_VAL[i];
                end else begin
                    meta_q[i] <= meta_d[i];
                    sync_q[i] <= sync_d[i];
                end
            end
        end
    endgenerate

    assign pin_sync = sync_q;

endmodule

/* File: mst_tx_gate.sv */
// Transmit start gate driven by the synchronised clear-to-send pin.
// Assumes the transmitter asks tx_start_req before each character and only
// starts one while tx_start_allow is high; a character already shifting is
// never cut short because this gate only governs starts.
`timescale 1ns/100ps

module mst_tx_gate (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic flow_en,
    input  wire logic cts_n_sync,
    input  wire logic tx_start_req,
    output logic      tx_start_allow,
    output logic      tx_halt_event
);

    logic allow_q;
    logic allow_d;
    logic halt_q;
    logic halt_d;
    logic halted_req_q;
    logic halted_req_d;

    // ======================================================================
    // Halt logic
    // ======================================================================
    always_comb begin
        halt_d       = flow_en && cts_n_sync;
        allow_d      = !halt_d;
        halted_req_d = halt_q && tx_start_req;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            halt_q       <= 1'b0;
            allow_q      <= 1'b1;
            halted_req_q <= 1'b0;
        end else begin
            halt_q       <= halt_d;
            allow_q      <= allow_d;
            halted_req_q <= halted_req_d;
        end
    end

    assign tx_start_allow = allow_q;
    // Pulse on the first cycle a pending start is held back.
    assign tx_halt_event  = halted_req_d && !halted_req_q;

endmodule

/* File: mst_top.sv */
// Modem status tracker: modem input status, change flags, interrupts and
// transmit flow control for one UART channel, with an Avalon-MM slave.
// Assumes one clock core_clk at 100 MHz and modem pins asynchronous to it.
//
// Contract
// - Outside loopback, status bits 7..4 show the complement of the CD, RI, DSR and CTS pins.
// - In loopback, status bits 7..4 show the second user output, first user output, DTR and RTS control bits.
// - The CD, DSR and CTS change flags in bits 3, 1 and 0 set on any change of their input.
// - The RI change flag in bit 2 sets only when the ring input pin goes from 0 to 1, or in loopback when the first user output bit goes from 1 to 0.
// - Every read of the modem line status register clears the change flags that it returns.
// - A modem status interrupt request stands while any change flag is set.
// - The CTS input gates transmission only while the control flow-enable bit is set.
// - With flow control on, a high CTS pin lets the current character finish and blocks new starts.
// - Reset clears the change flags and the upper status bits, which follow the inputs again three clock edges after reset.
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`include "mst_defs.svh"

module mst_top (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        cd_n,
    input  wire logic        ri_n,
    input  wire logic        dsr_n,
    input  wire logic        cts_n,
    output logic             dtr_n,
    output logic             rts_n,
    output logic             user_output_first_n,
    output logic             user_output_second_n,
    input  wire logic        tx_start_req,
    output logic             tx_start_allow,
    output logic             modem_irq_req,
    output logic             irq
);

    // ======================================================================
    // Declarations
    // ======================================================================
    mst_pkg::mst_modem_t     pin_n_sync;
    mst_pkg::mst_modem_t     live;
    mst_pkg::mst_modem_t     level_q;
    mst_pkg::mst_modem_t     level_d;
    mst_pkg::mst_bus_state_t state_q;
    mst_pkg::mst_bus_state_t state_d;
    logic [3:0]              flags_q;
    logic [3:0]              flags_d;
    logic [3:0]              flag_set;
    logic [3:0]              flags_seen_q;
    logic [3:0]              flags_seen_d;
    logic [1:0]              primed_q;
    logic [1:0]              primed_d;
    logic [`MST_MCR_W-1:0]   mcr_q;
    logic [`MST_MCR_W-1:0]   mcr_d;
    logic [`MST_IRQ_W-1:0]   irq_stat_q;
    logic [`MST_IRQ_W-1:0]   irq_stat_d;
    logic [`MST_IRQ_W-1:0]   irq_mask_q;
    logic [`MST_IRQ_W-1:0]   irq_mask_d;
    logic [31:0]             rdata_q;
    logic [31:0]             rdata_d;
    logic                    wait_q;
    logic                    wait_d;
    logic                    irq_q;
    logic                    irq_d;
    logic                    mreq_q;
    logic                    mreq_d;
    logic [3:0]              pins_q;
    logic [3:0]              pins_d;
    logic                    commit;
    logic                    wr_low;
    logic                    tx_halt_event;
    logic [`MST_IRQ_W-1:0]   irq_event;

    // ======================================================================
    // Helpers
    // ======================================================================
    function automatic logic addr_is(input logic [3:0] a, input logic [3:0] ofs);
        addr_is = (a == ofs);
    endfunction

    // ======================================================================
    // Input synchronisers and flow-control gate
    // ======================================================================
    mst_sync #(
        .WIDTH   (4),
        .RST_VAL (`MST_PIN_IDLE)
    ) u_sync (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .pin_async ({cd_n, ri_n, dsr_n, cts_n}),
        .pin_sync  (pin_n_sync)
    );

    mst_tx_gate u_tx_gate (
        .core_clk       (core_clk),
        .nrst           (nrst),
        .flow_en        (mcr_q[`MST_MCR_FLOW]),
        .cts_n_sync     (pin_n_sync.cts),
        .tx_start_req   (tx_start_req),
        .tx_start_allow (tx_start_allow),
        .tx_halt_event  (tx_halt_event)
    );

    // ======================================================================
    // Modem status levels and change flags
    // ======================================================================
    always_comb begin
        if (mcr_q[`MST_MCR_LOOP]) begin
            live.cd  = mcr_q[`MST_MCR_OUT2];
            live.ri  = mcr_q[`MST_MCR_OUT1];
            live.dsr = mcr_q[`MST_MCR_DTR];
            live.cts = mcr_q[`MST_MCR_RTS];
        end else begin
            live = ~pin_n_sync;
        end
        level_d  = live;
        // The synchroniser leaves reset at the idle level, so no edges are taken
        // until the level register holds a real pin sample; otherwise a pin that
        // is already active at reset would set a false change flag.
        primed_d = (primed_q == `MST_PRIME_EDGES) ? primed_q : primed_q + 2'd1;
        flag_set = '0;
        if (primed_q == `MST_PRIME_EDGES) begin
            flag_set[3] = live.cd  ^ level_q.cd;
            flag_set[2] = level_q.ri && !live.ri;
            flag_set[1] = live.dsr ^ level_q.dsr;
            flag_set[0] = live.cts ^ level_q.cts;
        end
        // Only the flags that were reported are cleared, and a new set wins.
        flags_d = flags_q;
        if (commit && read && addr_is(address, `MST_OFS_MODEM_LINE_STATUS)) begin
            flags_d = flags_q & ~flags_seen_q;
        end
        flags_d = flags_d | flag_set;
        mreq_d  = |flags_d;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            level_q  <= '0;
            flags_q  <= `MST_FLAGS_RST;
            primed_q <= 2'd0;
            mreq_q   <= 1'b0;
        end else begin
            level_q  <= level_d;
            flags_q  <= flags_d;
            primed_q <= primed_d;
            mreq_q   <= mreq_d;
        end
    end

    // ======================================================================
    // Avalon-MM slave: accept, then one answer cycle with waitrequest low
    // ======================================================================
    always_comb begin
        commit       = (state_q == mst_pkg::MST_BUS_ANSWER) && (read || write);
        wr_low       = commit && write && byteenable[0];
        state_d      = state_q;
        rdata_d      = rdata_q;
        flags_seen_d = flags_seen_q;
        mcr_d        = mcr_q;
        irq_mask_d   = irq_mask_q;
        irq_event    = {tx_halt_event, |flag_set};
        irq_stat_d   = irq_stat_q;
        unique case (state_q)
            mst_pkg::MST_BUS_IDLE: begin
                if (read || write) begin
                    state_d      = mst_pkg::MST_BUS_ANSWER;
                    rdata_d      = `MST_RDATA_RST;
                    flags_seen_d = flags_q;
                    if (read) begin
                        unique case (address)
                            `MST_OFS_MODEM_LINE_STATUS: rdata_d[7:0] = {level_q, flags_q};
                            `MST_OFS_MODEM_CONTROL_REG: rdata_d[`MST_MCR_W-1:0] = mcr_q;
                            `MST_OFS_IRQ_STATUS:        rdata_d[`MST_IRQ_W-1:0] = irq_stat_q;
                            `MST_OFS_IRQ_MASK:          rdata_d[`MST_IRQ_W-1:0] = irq_mask_q;
                            default:                    rdata_d = `MST_RDATA_RST;
                        endcase
                    end
                end
            end
            mst_pkg::MST_BUS_ANSWER: begin
                state_d = mst_pkg::MST_BUS_IDLE;
                if (wr_low && addr_is(address, `MST_OFS_MODEM_CONTROL_REG)) begin
                    mcr_d = writedata[`MST_MCR_W-1:0];
                end
                if (wr_low && addr_is(address, `MST_OFS_IRQ_MASK)) begin
                    irq_mask_d = writedata[`MST_IRQ_W-1:0];
                end
                if (wr_low && addr_is(address, `MST_OFS_IRQ_STATUS)) begin
                    irq_stat_d = irq_stat_q & ~writedata[`MST_IRQ_W-1:0];
                end
            end
        endcase
        irq_stat_d = irq_stat_d | irq_event;
        irq_d      = |(irq_stat_d & irq_mask_d);
        wait_d     = (state_d == mst_pkg::MST_BUS_IDLE);
        // Loopback parks the control pins at their inactive high level.
        if (mcr_d[`MST_MCR_LOOP]) begin
            pins_d = `MST_PIN_IDLE;
        end else begin
            pins_d = ~mcr_d[`MST_MCR_OUT2:`MST_MCR_DTR];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q      <= mst_pkg::MST_BUS_IDLE;
            rdata_q      <= `MST_RDATA_RST;
            flags_seen_q <= `MST_FLAGS_RST;
            mcr_q        <= `MST_MCR_RST;
            irq_stat_q   <= `MST_IRQ_RST;
            irq_mask_q   <= `MST_IRQ_RST;
            irq_q        <= 1'b0;
            wait_q       <= 1'b1;
            pins_q       <= `MST_PIN_IDLE;
        end else begin
            state_q      <= state_d;
            rdata_q      <= rdata_d;
            flags_seen_q <= flags_seen_d;
            mcr_q        <= mcr_d;
            irq_stat_q   <= irq_stat_d;
            irq_mask_q   <= irq_mask_d;
            irq_q        <= irq_d;
            wait_q       <= wait_d;
            pins_q       <= pins_d;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign readdata             = rdata_q;
    assign waitrequest          = wait_q;
    assign irq                  = irq_q;
    assign modem_irq_req        = mreq_q;
    assign dtr_n                = pins_q[0];
    assign rts_n                = pins_q[1];
    assign user_output_first_n  = pins_q[2];
    assign user_output_second_n = pins_q[3];

endmodule

/* File: mst_props.sv */
// Concurrent checks on the modem status tracker top ports.
// Assumes it is bound to mst_top and sees only that module's ports.
`timescale 1ns/100ps
`include "mst_defs.svh"

module mst_props (
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic [3:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        cd_n,
    input wire logic        ri_n,
    input wire logic        dsr_n,
    input wire logic        cts_n,
    input wire logic        dtr_n,
    input wire logic        rts_n,
    input wire logic        user_output_first_n,
    input wire logic        user_output_second_n,
    input wire logic        tx_start_req,
    input wire logic        tx_start_allow,
    input wire logic        modem_irq_req,
    input wire logic        irq
);
    // ======================================================================
    // Helpers
    // ======================================================================
    logic [31:0] wd_q;

    always_ff @(posedge core_clk) begin
        wd_q <= writedata;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_take;
        (read || write) && waitrequest;
    endsequence
    sequence s_wr_done(logic [3:0] a);
        write && !waitrequest && byteenable[0] && address == a;
    endsequence
    sequence s_cts_low;
        (!cts_n) [*6];
    endsequence

    // ======================================================================
    // Assertions
    // ======================================================================
    chk_wait_one: assert property (s_take |=> !waitrequest)
        else $error("no answer one cycle after accept");
    chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
        else $error("answer longer than one cycle");
    chk_wait_idle: assert property (waitrequest && !read && !write |=> waitrequest)
        else $error("answer without request");
    chk_rd_upper: assert property (read && !waitrequest |-> readdata[31:8] == 24'h00_0000)
        else $error("unused read bits not zero");
    chk_irq_req_rd: assert property (
        read && !waitrequest && address == `MST_OFS_MODEM_LINE_STATUS && readdata[3:0] != 4'h0 |-> modem_irq_req)
        else $error("change flag set without modem request");
    chk_mask_off: assert property (s_wr_done(`MST_OFS_IRQ_MASK) ##0 writedata[1:0] == 2'h0 |-> ##2 !irq)
        else $error("irq stays high with all sources masked");
    chk_ctl_pins: assert property (s_wr_done(`MST_OFS_MODEM_CONTROL_REG) |=>
        {user_output_second_n, user_output_first_n, rts_n, dtr_n} == (wd_q[4] ? 4'hF : ~wd_q[3:0]))
        else $error("control pins do not follow control write");
    chk_cts_allow: assert property (s_cts_low |-> tx_start_allow)
        else $error("starts blocked while clear to send");
endmodule

bind mst_top mst_props u_props (
    .core_clk(core_clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .cd_n(cd_n), .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n), .dtr_n(dtr_n), .rts_n(rts_n),
    .user_output_first_n(user_output_first_n), .user_output_second_n(user_output_second_n),
    .tx_start_req(tx_start_req), .tx_start_allow(tx_start_allow),
    .modem_irq_req(modem_irq_req), .irq(irq)
);

/* File: mst_modem_model.sv */
// Modem model driving the four active-low status pins.
// Assumes the bench sets the wanted levels; pins are asynchronous to core_clk.
`timescale 1ns/100ps

module mst_modem_model (
    input  wire mst_pkg::mst_modem_t want,
    input  wire logic                slow,
    output logic                     cd_n,
    output logic                     ri_n,
    output logic                     dsr_n,
    output logic                     cts_n
);
    initial {cd_n, ri_n, dsr_n, cts_n} = 4'hF;

    // A slow modem moves its lines late and off the clock edge, so the
    // synchroniser meets them at an arbitrary phase.
    always @(want) begin
        #(slow ? 37 : 3);
        {cd_n, ri_n, dsr_n, cts_n} = want;
    end
endmodule

/* File: tb.sv */
// Self-checking bench for the modem status tracker.
// Assumes mst_top, mst_props and mst_modem_model are compiled alongside.
`timescale 1ns/100ps

module tb;
    logic                core_clk = 1'b0;
    logic                nrst = 1'b0;
    logic [3:0]          address = 4'h0;
    logic                read = 1'b0;
    logic                write = 1'b0;
    logic [3:0]          byteenable = 4'hF;
    logic [31:0]         writedata = 32'h0000_0000;
    logic [31:0]         readdata;
    logic                waitrequest;
    logic                cd_n, ri_n, dsr_n, cts_n, dtr_n, rts_n;
    logic                user_output_first_n, user_output_second_n;
    logic                tx_start_req = 1'b0;
    logic                tx_start_allow, modem_irq_req, irq;
    mst_pkg::mst_modem_t want = 4'hF;
    logic                slow = 1'b0;
    logic [31:0]         rng = 32'h0000_0048;
    logic [31:0]         exp_q[$];
    int                  err_count = 0;
    int                  n_compared = 0;

    always #5 core_clk = ~core_clk;

    mst_top DUT (
        .core_clk(core_clk), .nrst(nrst), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .cd_n(cd_n), .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n), .dtr_n(dtr_n), .rts_n(rts_n),
        .user_output_first_n(user_output_first_n), .user_output_second_n(user_output_second_n),
        .tx_start_req(tx_start_req), .tx_start_allow(tx_start_allow),
        .modem_irq_req(modem_irq_req), .irq(irq)
    );

    mst_modem_model u_modem (
        .want(want), .slow(slow), .cd_n(cd_n), .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n)
    );

    // ======================================================================
    // Helpers
    // ======================================================================
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic fail(input string m);
        err_count++;
        $display("[FAIL] %0t %s", $time, m);
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        n_compared++;
        if (got !== exp) fail(m);
    endtask

    task automatic cmp_rd(input logic [31:0] got);
        n_compared++;
        if (exp_q.size() == 0) fail("read data without expectation");
        else if (got !== exp_q[0]) fail($sformatf("read got %h want %h", got, exp_q[0]));
        if (exp_q.size() != 0) void'(exp_q.pop_front());
    endtask

    task automatic complete_run;
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Upper data and byte-enable bits are random noise the slave must ignore.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic be0);
        int k;
        rng = xs(rng);
        @(posedge core_clk);
        read <= !wr;
        write <= wr;
        address <= a;
        byteenable <= {rng[2:0], be0};
        writedata <= {rng[31:8], d};
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 20);
        if (k >= 20) fail("bus answer missing");
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00, 1'b1);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 1'b1);
    endtask

    // Read data are taken at the edge where waitrequest is sampled low.
    always @(posedge core_clk) begin
        if (read === 1'b1 && waitrequest === 1'b0) cmp_rd(readdata);
    end

    initial begin
        #200000;
        fail("watchdog expired");
        complete_run();
    end

    // ======================================================================
    // Scenarios
    // ======================================================================
    initial begin
        wt(3);
        nrst <= 1'b1;
        rd(4'h0, 32'h0000_0000);
        rd(4'h4, 32'h0000_0000);
        rd(4'h8, 32'h0000_0000);
        rd(4'hC, 32'h0000_0000);
        rd(4'h2, 32'h0000_0000);
        wr(4'h0, 8'hFF);
        rd(4'h0, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            slow <= i[0];
            want <= 4'hF ^ (4'h1 << i);
            wt(8);
            chk_bit(modem_irq_req, i != 2, "modem request after assert");
            rd(4'h0, (32'h10 << i) | ((i == 2) ? 32'h0 : (32'h1 << i)));
            rd(4'h0, 32'h10 << i);
            wt(2);
            chk_bit(modem_irq_req, 1'b0, "modem request after clear");
            want <= 4'hF;
            wt(8);
            rd(4'h0, 32'h1 << i);
            rd(4'h0, 32'h0000_0000);
        end
        wr(4'hC, 8'h01);
        want <= 4'hE;
        wt(8);
        chk_bit(irq, 1'b1, "irq after unmasked change");
        rd(4'h8, 32'h0000_0001);
        rd(4'h0, 32'h0000_0011);
        wr(4'h8, 8'h01);
        wt(3);
        chk_bit(irq, 1'b0, "irq after status clear");
        wr(4'hC, 8'h00);
        want <= 4'hF;
        wt(8);
        chk_bit(irq, 1'b0, "irq while masked");
        chk_bit(modem_irq_req, 1'b1, "modem request while masked");
        rd(4'h0, 32'h0000_0001);
        wr(4'h4, 8'h1F);
        wt(3);
        chk_bit(dtr_n & rts_n & user_output_first_n & user_output_second_n, 1'b1, "pins in loopback");
        rd(4'h0, 32'h0000_00FB);
        wr(4'h4, 8'h10);
        rd(4'h0, 32'h0000_000F);
        bus(1'b1, 4'h4, 8'h03, 1'b0);
        rd(4'h4, 32'h0000_0010);
        wr(4'h4, 8'h03);
        rd(4'h4, 32'h0000_0003);
        chk_bit(dtr_n | rts_n, 1'b0, "control pins after write");
        rd(4'h0, 32'h0000_0000);
        wr(4'h8, 8'h03);
        tx_start_req <= 1'b1;
        wt(6);
        chk_bit(tx_start_allow, 1'b1, "flow off ignores cts");
        wr(4'h4, 8'h20);
        wt(4);
        chk_bit(tx_start_allow, 1'b0, "cts high halts starts");
        rd(4'h8, 32'h0000_0002);
        want <= 4'hE;
        wt(8);
        chk_bit(tx_start_allow, 1'b1, "cts low resumes starts");
        tx_start_req <= 1'b0;
        nrst <= 1'b0;
        wt(2);
        nrst <= 1'b1;
        wt(4);
        rd(4'h0, 32'h0000_0010);
        wt(2);
        complete_run();
    end
endmodule
